// ---- rtl/atx_pkg.sv ----
package atx_pkg;

  // Register port
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam logic [7:0] OFS_MONO_CTRL = 8'h01;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h05;

  // Mono and format control fields
  localparam int unsigned BIT_MONO_EN = 0;
  localparam int unsigned BIT_MONO_SRC = 1;
  localparam int unsigned BIT_MONO_CS_SRC = 2;
  localparam logic [7:0] RST_MONO_CTRL = 8'h00;
  localparam logic [7:0] MONO_CTRL_USED = 8'h07;

  // Interrupt status fields; bit 2 stays reserved for a third source
  localparam int unsigned BIT_CS_DONE = 0;
  localparam int unsigned BIT_SLIP_BLK = 1;
  localparam int unsigned N_FLAGS = 2;
  localparam logic [N_FLAGS-1:0] FLAGS_CLEAR = 2'h0;

  // Interrupt mask control fields; a 1 in bit 0 or 1 masks that source, a 1 in bit 2 selects block start for flag 1
  localparam int unsigned BIT_MASK_CS_DONE = 0;
  localparam int unsigned BIT_MASK_SLIP_BLK = 1;
  localparam int unsigned BIT_SLIP_BLK_SEL = 2;
  localparam logic [7:0] RST_IRQ_MASK = 8'h00;
  localparam logic [7:0] IRQ_MASK_USED = 8'h07;

  // Sample path
  localparam int unsigned SAMPLE_W = 24;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned FIFO_W = 2 * SAMPLE_W + 2;
  localparam int unsigned POS_RIGHT = 0;
  localparam int unsigned POS_LEFT = SAMPLE_W;
  localparam int unsigned POS_CS_B = 2 * SAMPLE_W;
  localparam int unsigned POS_CS_A = 2 * SAMPLE_W + 1;

  // Pin synchroniser lanes
  localparam int unsigned N_PINS = 4;
  localparam int unsigned PIN_SW_MODE = 0;
  localparam int unsigned PIN_MONO = 1;
  localparam int unsigned PIN_MONO_SRC = 2;
  localparam int unsigned PIN_BLK_SYNC = 3;
  localparam logic [N_PINS-1:0] PINS_RST = 4'h0;

  typedef enum logic [0:0] {
    st_idle,
    st_second
  } atx_state_t;

endpackage

// ---- rtl/atx_fifo.sv ----
`timescale 1ns/100ps
`default_nettype none

module atx_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PTR_W:0] DEPTH_CNT = DEPTH[PTR_W:0];
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_ff;
  logic [PTR_W-1:0] rd_ptr_ff;
  logic [PTR_W:0] count_ff;
  logic push;
  logic pop;

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    ptr_inc = (p == LAST_PTR) ? '0 : p + 1'b1;
  endfunction

  assign in_ready = (count_ff != DEPTH_CNT);
  assign out_valid = (count_ff != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_ptr_ff];

  always_ff @(posedge ref_clk)
  begin
    if (push)
    begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_ff <= ptr_inc(wr_ptr_ff);
      end
      if (pop)
      begin
        rd_ptr_ff <= ptr_inc(rd_ptr_ff);
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      count_ff <= '0;
    end
    else if (push && !pop)
    begin
      count_ff <= count_ff + 1'b1;
    end
    else if (pop && !push)
    begin
      count_ff <= count_ff - 1'b1;
    end
  end

endmodule

`default_nettype wire

// ---- rtl/atx_irq_mono.sv ----
`timescale 1ns/100ps
`default_nettype none

module atx_irq_mono (
  input wire logic ref_clk,
  input wire logic rst_n,
  // Control mode, hardware mono and block sync pins, asynchronous
  input wire logic sw_mode_pin,
  input wire logic mono_enable_pin,
  input wire logic mono_source_select_pin,
  input wire logic block_sync_input,
  // Register port from the serial control decoder
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [atx_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [atx_pkg::DATA_W-1:0] reg_wdata,
  output logic [atx_pkg::DATA_W-1:0] reg_rdata,
  // Internal event pulses
  input wire logic cs_xfer_done,
  input wire logic int_block_start,
  // Audio samples from the serial audio port
  input wire logic audio_valid,
  output logic audio_ready,
  input wire logic [atx_pkg::SAMPLE_W-1:0] audio_left,
  input wire logic [atx_pkg::SAMPLE_W-1:0] audio_right,
  input wire logic cs_a_bit,
  input wire logic cs_b_bit,
  // Frame request and subframe data toward the encoder
  input wire logic frame_req,
  output logic frame_valid,
  output logic [atx_pkg::SAMPLE_W-1:0] sub_a_data,
  output logic [atx_pkg::SAMPLE_W-1:0] sub_b_data,
  output logic sub_a_cs,
  output logic sub_b_cs,
  output logic slip_pulse,
  // Open-drain interrupt pin, active low
  output logic int_n_out,
  output logic int_n_oe_n
);

  logic [atx_pkg::N_PINS-1:0] sync1_ff;
  logic [atx_pkg::N_PINS-1:0] sync2_ff;
  logic blk_prev_ff;
  logic sw_mode;
  logic blk_rise;

  logic [atx_pkg::DATA_W-1:0] mono_ctrl_ff;
  logic [atx_pkg::DATA_W-1:0] irq_mask_ff;
  logic [atx_pkg::N_FLAGS-1:0] status_ff;
  logic [atx_pkg::N_FLAGS-1:0] nxt_status;
  logic [atx_pkg::N_FLAGS-1:0] events;
  logic [atx_pkg::N_FLAGS-1:0] unmasked;
  logic [atx_pkg::DATA_W-1:0] reg_rdata_ff;
  logic [atx_pkg::DATA_W-1:0] nxt_rdata;
  logic status_read;

  logic mono_en;
  logic mono_src;
  logic mono_cs_src;

  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [atx_pkg::FIFO_W-1:0] fifo_in_word;
  logic [atx_pkg::FIFO_W-1:0] fifo_out_word;
  logic [atx_pkg::FIFO_W-1:0] last_word_ff;
  logic [atx_pkg::FIFO_W-1:0] cur_word;
  logic need_word;
  logic drop_evt;
  logic repeat_evt;
  logic slip_evt;

  atx_pkg::atx_state_t state_ff;
  atx_pkg::atx_state_t nxt_state;
  logic frame_mono_ff;
  logic frame_valid_ff;
  logic [atx_pkg::SAMPLE_W-1:0] sub_a_data_ff;
  logic [atx_pkg::SAMPLE_W-1:0] sub_b_data_ff;
  logic sub_a_cs_ff;
  logic sub_b_cs_ff;
  logic slip_pulse_ff;

  // Picks one channel's sample out of a stored word
  function automatic logic [atx_pkg::SAMPLE_W-1:0] pick_sample(
    input logic [atx_pkg::FIFO_W-1:0] w,
    input logic right
  );
    pick_sample = right ? w[atx_pkg::POS_RIGHT +: atx_pkg::SAMPLE_W]
                        : w[atx_pkg::POS_LEFT +: atx_pkg::SAMPLE_W];
  endfunction

  // Picks one channel's status bit out of a stored word
  function automatic logic pick_cs(
    input logic [atx_pkg::FIFO_W-1:0] w,
    input logic chan_b
  );
    pick_cs = chan_b ? w[atx_pkg::POS_CS_B] : w[atx_pkg::POS_CS_A];
  endfunction

  // Pins come from outside; two flops before any use
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      sync1_ff <= atx_pkg::PINS_RST;
      sync2_ff <= atx_pkg::PINS_RST;
      blk_prev_ff <= 1'b0;
    end
    else
    begin
      sync1_ff <= {block_sync_input, mono_source_select_pin,
                   mono_enable_pin, sw_mode_pin};
      sync2_ff <= sync1_ff;
      blk_prev_ff <= sync2_ff[atx_pkg::PIN_BLK_SYNC];
    end
  end

  assign sw_mode = sync2_ff[atx_pkg::PIN_SW_MODE];
  assign blk_rise = sync2_ff[atx_pkg::PIN_BLK_SYNC] & ~blk_prev_ff;

  // Control registers
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      mono_ctrl_ff <= atx_pkg::RST_MONO_CTRL;
    end
    else if (reg_wr && reg_addr == atx_pkg::OFS_MONO_CTRL)
    begin
      mono_ctrl_ff <= reg_wdata & atx_pkg::MONO_CTRL_USED;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      irq_mask_ff <= atx_pkg::RST_IRQ_MASK;
    end
    else if (reg_wr && reg_addr == atx_pkg::OFS_IRQ_MASK)
    begin
      irq_mask_ff <= reg_wdata & atx_pkg::IRQ_MASK_USED;
    end
  end

  // hardware mode: one source pin for audio and status; software mode: separate register bits
  always_comb
  begin
    if (sw_mode)
    begin
      mono_en = mono_ctrl_ff[atx_pkg::BIT_MONO_EN];
      mono_src = mono_ctrl_ff[atx_pkg::BIT_MONO_SRC];
      mono_cs_src = mono_ctrl_ff[atx_pkg::BIT_MONO_CS_SRC];
    end
    else
    begin
      mono_en = sync2_ff[atx_pkg::PIN_MONO];
      mono_src = sync2_ff[atx_pkg::PIN_MONO_SRC];
      mono_cs_src = sync2_ff[atx_pkg::PIN_MONO_SRC];
    end
  end

  // Sample buffer between the audio port and the frame builder
  assign fifo_in_word = {cs_a_bit, cs_b_bit, audio_left, audio_right};

  atx_fifo #(
    .WIDTH(atx_pkg::FIFO_W),
    .DEPTH(atx_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(audio_valid),
    .in_ready(audio_ready),
    .in_data(fifo_in_word),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_word)
  );

  // A word is needed on each frame request, and once more in mono
  assign need_word = (state_ff == atx_pkg::st_second) ||
                     (state_ff == atx_pkg::st_idle && frame_req);
  assign fifo_out_ready = need_word;
  // Empty buffer repeats the last sample rather than stalling the line
  assign cur_word = fifo_out_valid ? fifo_out_word : last_word_ff;

  assign drop_evt = audio_valid & ~audio_ready;
  assign repeat_evt = need_word & ~fifo_out_valid;
  assign slip_evt = drop_evt | repeat_evt;

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      atx_pkg::st_idle:
      begin
        if (frame_req && mono_en)
        begin
          nxt_state = atx_pkg::st_second;
        end
      end
      atx_pkg::st_second:
      begin
        nxt_state = atx_pkg::st_idle;
      end
      default:
      begin
        nxt_state = atx_pkg::st_idle;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state_ff <= atx_pkg::st_idle;
      frame_mono_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      if (state_ff == atx_pkg::st_idle && frame_req)
      begin
        frame_mono_ff <= mono_en;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      last_word_ff <= '0;
    end
    else if (need_word && fifo_out_valid)
    begin
      last_word_ff <= fifo_out_word;
    end
  end

  // mono puts two consecutive samples into A then B
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      sub_a_data_ff <= '0;
      sub_b_data_ff <= '0;
      sub_a_cs_ff <= 1'b0;
      sub_b_cs_ff <= 1'b0;
      frame_valid_ff <= 1'b0;
    end
    else
    begin
      frame_valid_ff <= 1'b0;
      if (state_ff == atx_pkg::st_idle && frame_req)
      begin
        if (mono_en)
        begin
          sub_a_data_ff <= pick_sample(cur_word, mono_src);
          sub_a_cs_ff <= pick_cs(cur_word, mono_cs_src);
        end
        else
        begin
          sub_a_data_ff <= pick_sample(cur_word, 1'b0);
          sub_b_data_ff <= pick_sample(cur_word, 1'b1);
          sub_a_cs_ff <= pick_cs(cur_word, 1'b0);
          sub_b_cs_ff <= pick_cs(cur_word, 1'b1);
          frame_valid_ff <= 1'b1;
        end
      end
      else if (state_ff == atx_pkg::st_second && frame_mono_ff)
      begin
        sub_b_data_ff <= pick_sample(cur_word, mono_src);
        sub_b_cs_ff <= pick_cs(cur_word, mono_cs_src);
        frame_valid_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      slip_pulse_ff <= 1'b0;
    end
    else
    begin
      slip_pulse_ff <= slip_evt;
    end
  end

  assign events[atx_pkg::BIT_CS_DONE] = cs_xfer_done;
  assign events[atx_pkg::BIT_SLIP_BLK] =
    irq_mask_ff[atx_pkg::BIT_SLIP_BLK_SEL] ? (int_block_start | blk_rise)
                                           : slip_evt;

  assign unmasked[atx_pkg::BIT_CS_DONE] =
    ~irq_mask_ff[atx_pkg::BIT_MASK_CS_DONE];
  assign unmasked[atx_pkg::BIT_SLIP_BLK] =
    ~irq_mask_ff[atx_pkg::BIT_MASK_SLIP_BLK];

  assign status_read = reg_rd && (reg_addr == atx_pkg::OFS_IRQ_STATUS);

  // A new event in the read cycle survives the clear
  always_comb
  begin
    nxt_status = status_ff;
    if (!sw_mode)
    begin
      nxt_status = atx_pkg::FLAGS_CLEAR;
    end
    else
    begin
      if (status_read)
      begin
        nxt_status = atx_pkg::FLAGS_CLEAR;
      end
      nxt_status = nxt_status | (events & unmasked);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      status_ff <= atx_pkg::FLAGS_CLEAR;
    end
    else
    begin
      status_ff <= nxt_status;
    end
  end

  always_comb
  begin
    nxt_rdata = '0;
    case (reg_addr)
      atx_pkg::OFS_MONO_CTRL:
      begin
        nxt_rdata = mono_ctrl_ff;
      end
      atx_pkg::OFS_IRQ_STATUS:
      begin
        nxt_rdata[atx_pkg::N_FLAGS-1:0] = status_ff;
      end
      atx_pkg::OFS_IRQ_MASK:
      begin
        nxt_rdata = irq_mask_ff;
      end
      default:
      begin
        nxt_rdata = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      reg_rdata_ff <= '0;
    end
    else if (reg_rd)
    begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = reg_rdata_ff;
  assign frame_valid = frame_valid_ff;
  assign sub_a_data = sub_a_data_ff;
  assign sub_b_data = sub_b_data_ff;
  assign sub_a_cs = sub_a_cs_ff;
  assign sub_b_cs = sub_b_cs_ff;
  assign slip_pulse = slip_pulse_ff;

  // drive low while any flag set, else float for pull-up
  assign int_n_out = 1'b0;
  assign int_n_oe_n = ~(|status_ff);

endmodule

`default_nettype wire

// ---- tb/atx_irq_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
module atx_irq_chk (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic sw_mode_pin,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [atx_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [atx_pkg::DATA_W-1:0] reg_wdata,
  input wire logic [atx_pkg::DATA_W-1:0] reg_rdata,
  input wire logic cs_xfer_done,
  input wire logic int_n_out,
  input wire logic int_n_oe_n
);
  logic [1:0] mask_ff;
  // Mirror of the source masks
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      mask_ff <= 2'h0;
    else if (reg_wr && reg_addr == atx_pkg::OFS_IRQ_MASK)
      mask_ff <= reg_wdata[1:0];
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_hw_idle;
    !sw_mode_pin [*4];
  endsequence
  // Pin synchroniser needs a few edges after reset and after a change
  sequence s_sw_held;
    sw_mode_pin && $past(sw_mode_pin) && $past(sw_mode_pin, 2) &&
      $past(sw_mode_pin, 3) && $past(rst_n, 4);
  endsequence
  sequence s_status_rd;
    reg_rd && reg_addr == atx_pkg::OFS_IRQ_STATUS;
  endsequence
  od_low_a: assert property (int_n_out == 1'b0)
    else $error("interrupt pin data not low");
  hw_quiet_a: assert property (s_hw_idle |=> int_n_oe_n)
    else $error("interrupt active in hardware mode");
  xfer_set_a: assert property (s_sw_held ##0
    (cs_xfer_done && !mask_ff[0]) |=> !int_n_oe_n)
    else $error("transfer done did not raise interrupt");
  irq_hold_a: assert property (s_sw_held ##0
    (!int_n_oe_n && !reg_rd) |=> !int_n_oe_n)
    else $error("interrupt released without a read");
  mask_blk_a: assert property (int_n_oe_n && mask_ff == 2'h3
    |=> int_n_oe_n)
    else $error("masked source raised interrupt");
  rd_clear_a: assert property (s_status_rd ##0 mask_ff == 2'h3
    |=> int_n_oe_n)
    else $error("status read did not release interrupt");
  rd_flags_a: assert property (s_status_rd ##0 !int_n_oe_n
    |=> reg_rdata[1:0] != 2'h0)
    else $error("interrupt low but no flag read");
  rd_resv_a: assert property (s_status_rd |=> reg_rdata[7:2] == 6'h00)
    else $error("reserved status bits set");
endmodule
`default_nettype wire

// ---- tb/atx_host.sv ----
`timescale 1ns/100ps
`default_nettype none
module atx_host (
  input wire logic ref_clk,
  input wire logic [atx_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic [atx_pkg::ADDR_W-1:0] reg_addr,
  output logic [atx_pkg::DATA_W-1:0] reg_wdata
);
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk) #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge ref_clk) #1;
    reg_wr = 1'b0;
    // Idle lines flip so a stale value is never trusted
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk) #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge ref_clk) #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic ref_clk, rst_n, sw_mode_pin, mono_enable_pin;
  logic mono_source_select_pin, block_sync_input, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic cs_xfer_done, int_block_start, audio_valid, audio_ready;
  logic [23:0] audio_left, audio_right, sub_a_data, sub_b_data;
  logic cs_a_bit, cs_b_bit, frame_req, frame_valid, sub_a_cs, sub_b_cs;
  logic slip_pulse, int_n_out, int_n_oe_n, int_pin;
  int mismatches = 0;
  int n_tests = 0;
  // Pull-up wins whenever the pin is released
  assign int_pin = int_n_oe_n ? 1'b1 : int_n_out;
  atx_irq_mono u_dut (.ref_clk, .rst_n, .sw_mode_pin, .mono_enable_pin,
    .mono_source_select_pin, .block_sync_input, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .cs_xfer_done, .int_block_start,
    .audio_valid, .audio_ready, .audio_left, .audio_right, .cs_a_bit,
    .cs_b_bit, .frame_req, .frame_valid, .sub_a_data, .sub_b_data,
    .sub_a_cs, .sub_b_cs, .slip_pulse, .int_n_out, .int_n_oe_n);
  atx_host u_host (.ref_clk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata);
  always #20 ref_clk = ~ref_clk;
  task automatic stop_test();
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk_bit(input logic g, input logic e);
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_val(input logic [23:0] g, input logic [23:0] e);
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    u_host.rd(a, rv);
    chk_val({16'h0, rv}, {16'h0, e});
  endtask
  task automatic pulse(ref logic s);
    @(posedge ref_clk) #1;
    s = 1'b1;
    @(posedge ref_clk) #1;
    s = 1'b0;
  endtask
  task automatic push(input logic [23:0] l, input logic [23:0] r,
    input logic a, input logic b);
    @(posedge ref_clk) #1;
    audio_valid = 1'b1;
    audio_left = l;
    audio_right = r;
    cs_a_bit = a;
    cs_b_bit = b;
    @(posedge ref_clk) #1;
    audio_valid = 1'b0;
    audio_left = ~l;
    audio_right = ~r;
  endtask
  task automatic frame();
    pulse(frame_req);
    repeat (2) if (frame_valid !== 1'b1) @(posedge ref_clk) #1;
    chk_bit(frame_valid, 1'b1);
  endtask
  task automatic t_regs();
    rchk(atx_pkg::OFS_MONO_CTRL, atx_pkg::RST_MONO_CTRL);
    rchk(atx_pkg::OFS_IRQ_STATUS, 8'h00);
    rchk(atx_pkg::OFS_IRQ_MASK, atx_pkg::RST_IRQ_MASK);
    rchk(8'h02, 8'h00);
    u_host.wr(atx_pkg::OFS_MONO_CTRL, 8'hff);
    rchk(atx_pkg::OFS_MONO_CTRL, atx_pkg::MONO_CTRL_USED);
    u_host.wr(atx_pkg::OFS_IRQ_MASK, 8'hff);
    rchk(atx_pkg::OFS_IRQ_MASK, atx_pkg::IRQ_MASK_USED);
    u_host.wr(atx_pkg::OFS_IRQ_STATUS, 8'hff);
    rchk(atx_pkg::OFS_IRQ_STATUS, 8'h00);
    u_host.wr(atx_pkg::OFS_MONO_CTRL, 8'h00);
  endtask
  task automatic t_irq();
    u_host.wr(atx_pkg::OFS_IRQ_MASK, 8'h01);
    pulse(cs_xfer_done);
    chk_bit(int_pin, 1'b1);
    rchk(atx_pkg::OFS_IRQ_STATUS, 8'h00);
    u_host.wr(atx_pkg::OFS_IRQ_MASK, 8'h00);
    pulse(cs_xfer_done);
    chk_bit(int_pin, 1'b0);
    repeat (3) @(posedge ref_clk) #1;
    chk_bit(int_pin, 1'b0);
    rchk(atx_pkg::OFS_IRQ_STATUS, 8'h01);
    chk_bit(int_pin, 1'b1);
  endtask
  task automatic t_blk();
    u_host.wr(atx_pkg::OFS_IRQ_MASK, 8'h04);
    pulse(int_block_start);
    rchk(atx_pkg::OFS_IRQ_STATUS, 8'h02);
    block_sync_input = 1'b1;
    repeat (6) @(posedge ref_clk) #1;
    block_sync_input = 1'b0;
    rchk(atx_pkg::OFS_IRQ_STATUS, 8'h02);
    rchk(atx_pkg::OFS_IRQ_STATUS, 8'h00);
    u_host.wr(atx_pkg::OFS_IRQ_MASK, 8'h00);
    pulse(int_block_start);
    rchk(atx_pkg::OFS_IRQ_STATUS, 8'h00);
  endtask
  task automatic t_fifo();
    for (int i = 0; i < 9; i++)
      push(24'(i), 24'(i + 256), i[0], ~i[0]);
    chk_bit(audio_ready, 1'b0);
    chk_bit(slip_pulse, 1'b1);
    rchk(atx_pkg::OFS_IRQ_STATUS, 8'h02);
    for (int i = 0; i < 8; i++)
    begin
      frame();
      chk_val(sub_a_data, 24'(i));
      chk_val(sub_b_data, 24'(i + 256));
      chk_bit(sub_a_cs, i[0]);
      chk_bit(sub_b_cs, ~i[0]);
      chk_bit(slip_pulse, 1'b0);
    end
    rchk(atx_pkg::OFS_IRQ_STATUS, 8'h00);
    frame();
    chk_val(sub_a_data, 24'h7);
    chk_bit(slip_pulse, 1'b1);
    rchk(atx_pkg::OFS_IRQ_STATUS, 8'h02);
  endtask
  task automatic t_mono(input logic hw, input logic [2:0] m);
    sw_mode_pin = ~hw;
    mono_enable_pin = m[0];
    mono_source_select_pin = m[1];
    if (!hw)
      u_host.wr(atx_pkg::OFS_MONO_CTRL, {5'h0, m});
    repeat (4) @(posedge ref_clk) #1;
    push(24'ha1, 24'hb1, 1'b1, 1'b0);
    push(24'ha2, 24'hb2, 1'b0, 1'b1);
    frame();
    chk_val(sub_a_data, m[1] ? 24'hb1 : 24'ha1);
    chk_val(sub_b_data, m[1] ? 24'hb2 : 24'ha2);
    chk_bit(sub_a_cs, ~m[2]);
    chk_bit(sub_b_cs, m[2]);
  endtask
  task automatic t_hw();
    pulse(cs_xfer_done);
    chk_bit(int_pin, 1'b1);
    sw_mode_pin = 1'b1;
    repeat (4) @(posedge ref_clk) #1;
    rchk(atx_pkg::OFS_IRQ_STATUS, 8'h00);
  endtask
  initial
  begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    sw_mode_pin = 1'b1;
    {mono_enable_pin, mono_source_select_pin, block_sync_input} = 3'h0;
    {cs_xfer_done, int_block_start, audio_valid, frame_req} = 4'h0;
    {cs_a_bit, cs_b_bit, audio_left, audio_right} = 50'h0;
    repeat (4) @(posedge ref_clk) #1;
    rst_n = 1'b1;
    repeat (3) @(posedge ref_clk) #1;
    t_regs();
    t_irq();
    t_blk();
    t_fifo();
    t_mono(1'b0, 3'b011);
    t_mono(1'b0, 3'b101);
    t_mono(1'b1, 3'b111);
    t_mono(1'b1, 3'b001);
    t_hw();
    stop_test();
  end
  initial
  begin
    #100000;
    mismatches++;
    stop_test();
  end
endmodule
bind atx_irq_mono atx_irq_chk u_chk (.ref_clk, .rst_n, .sw_mode_pin,
  .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .cs_xfer_done,
  .int_n_out, .int_n_oe_n);
`default_nettype wire
